// ### hub_reset_attach_control.sv
// Reset pad states, strap capture, configuration source and attach control.
// Assumes engine-side inputs share REF_CLK_I; pin levels are asynchronous.
`timescale 1ns/1ps
module hub_reset_attach_control
    import hub_reset_attach_pkg::*;
#(
    parameter longint unsigned DROP_CYCLES = PULLUP_DROP_CYCLES,
    parameter int PORTS = 2
) (
    // Clock, reset, enable
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    // Asynchronous pin levels
    input wire logic UPSTREAM_POWER_SENSE_I,
    input wire logic FLASH_SPEED_STRAP_I,
    // Configuration loader handshake
    input wire logic CFG_PROBE_DONE_I,
    input wire logic CFG_FLASH_FOUND_I,
    input wire logic CFG_EEPROM_FOUND_I,
    input wire logic CFG_LOAD_DONE_I,
    // Engine-side requests
    input wire logic [PORTS-1:0] PORT_POWER_REQ_I,
    input wire logic LED_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_CLK_I,
    input wire logic SPI_DO_I,
    // Upstream attach and pads
    output logic UP_PULLUP_EN_O,
    output logic UP_PAIR_PAD_EN_O,
    output logic CARD_PAD_EN_O,
    output logic CARD_DETECT_N_PU_O,
    // Port power control pads
    output logic [PORTS-1:0] PORT_POWER_CTL_O,
    output logic [PORTS-1:0] PORT_POWER_CTL_OE_O,
    output logic [PORTS-1:0] PORT_POWER_CTL_PU_O,
    // Serial and misc pads
    output logic LED_O,
    output logic SPI_CS_N_O,
    output logic SPI_CLK_O,
    output logic SPI_DO_O,
    output logic SPI_DO_OE_O,
    output logic FLASH_SPEED_STRAP_PD_O,
    output logic DN_DATA_IE_O,
    output logic DN_DATA_PD_O,
    output logic SPI_DI_PD_O,
    output logic TEST_PD_O,
    // Status
    output logic FLASH_SPEED_O,
    output logic [1:0] CFG_SRC_O,
    output logic CFG_DONE_O,
    output logic [1:0] TT_COUNT_O,
    output logic [2:0] TT_NP_BUFFERS_O
);
    logic [1:0] pin_s;
    logic vbus_s;
    logic strap_s;
    logic [1:0] phase_reg;
    logic live;
    cfg_state_t cfg_state_reg;
    cfg_state_t cfg_state_next;
    cfg_src_t cfg_src_reg;
    cfg_src_t cfg_src_next;
    logic pullup_next;

    hub_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .ce_i(CE_I),
        .d_i({UPSTREAM_POWER_SENSE_I, FLASH_SPEED_STRAP_I}),
        .q_o(pin_s)
    );

    assign vbus_s = pin_s[1];
    assign strap_s = pin_s[0];
    assign live = (phase_reg == RELEASE_PHASE);

    // Release sequencer: pads stay in reset state until the strap is taken
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            phase_reg <= 2'h0;
        else if (CE_I && !live)
            phase_reg <= phase_reg + 2'h1;
    end

    // Strap waits two clocks so the synchroniser holds a post-reset level
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            FLASH_SPEED_O <= 1'b0;
        else if (CE_I && phase_reg == STRAP_SAMPLE_PHASE)
            FLASH_SPEED_O <= strap_s;
    end

    // Configuration source selection
    always_comb
    begin
        cfg_state_next = cfg_state_reg;
        cfg_src_next = cfg_src_reg;
        case (cfg_state_reg)
            CFG_HOLD:
                if (live)
                    cfg_state_next = CFG_PROBE;
            CFG_PROBE:
                if (CFG_PROBE_DONE_I)
                begin
                    if (CFG_FLASH_FOUND_I)
                    begin
                        cfg_src_next = SRC_FLASH;
                        cfg_state_next = CFG_LOAD;
                    end
                    else if (CFG_EEPROM_FOUND_I)
                    begin
                        cfg_src_next = SRC_EEPROM;
                        cfg_state_next = CFG_LOAD;
                    end
                    else
                    begin
                        cfg_src_next = SRC_DEFAULT;
                        cfg_state_next = CFG_READY;
                    end
                end
            CFG_LOAD:
                if (CFG_LOAD_DONE_I)
                    cfg_state_next = CFG_READY;
            CFG_READY:
                cfg_state_next = CFG_READY;
            default:
                cfg_state_next = CFG_HOLD;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            cfg_state_reg <= CFG_HOLD;
            cfg_src_reg <= SRC_NONE;
        end
        else if (CE_I)
        begin
            cfg_state_reg <= cfg_state_next;
            cfg_src_reg <= cfg_src_next;
        end
    end

    // Pull-up drops on the first clock that sees power gone, far inside 10 s
    assign pullup_next = (cfg_state_reg == CFG_READY) && vbus_s;

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            UP_PULLUP_EN_O <= 1'b0;
            CFG_SRC_O <= SRC_NONE;
            CFG_DONE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            UP_PULLUP_EN_O <= pullup_next;
            CFG_SRC_O <= cfg_src_reg;
            CFG_DONE_O <= (cfg_state_reg == CFG_READY);
        end
    end

    // Fixed translator shape reported to the hub engine
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            TT_COUNT_O <= TT_COUNT;
            TT_NP_BUFFERS_O <= TT_NP_BUFFERS;
        end
        else if (CE_I)
        begin
            TT_COUNT_O <= TT_COUNT;
            TT_NP_BUFFERS_O <= TT_NP_BUFFERS;
        end
    end

    // Port power: open drain high when on, driven low with pull-up off
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            PORT_POWER_CTL_O <= '0;
            PORT_POWER_CTL_OE_O <= '1;
            PORT_POWER_CTL_PU_O <= '0;
        end
        else if (CE_I)
        begin
            PORT_POWER_CTL_O <= '0;
            PORT_POWER_CTL_OE_O <= live ? ~PORT_POWER_REQ_I : '1;
            PORT_POWER_CTL_PU_O <= live ? PORT_POWER_REQ_I : '0;
        end
    end

    // Pad states: fixed in reset, handed to the engines once live, but CARD_DETECT_N_PU_O, DN_DATA_IE_O and TEST_PD_O stay fixed
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            UP_PAIR_PAD_EN_O <= 1'b0;
            CARD_PAD_EN_O <= 1'b0;
            CARD_DETECT_N_PU_O <= 1'b1;
            LED_O <= RST_DRIVE_LOW;
            SPI_CS_N_O <= RST_SPI_CS_N;
            SPI_CLK_O <= RST_DRIVE_LOW;
            SPI_DO_O <= RST_DRIVE_LOW;
            SPI_DO_OE_O <= 1'b0;
            FLASH_SPEED_STRAP_PD_O <= 1'b1;
            DN_DATA_IE_O <= 1'b1;
            DN_DATA_PD_O <= 1'b1;
            SPI_DI_PD_O <= 1'b1;
            TEST_PD_O <= 1'b1;
        end
        else if (CE_I)
        begin
            UP_PAIR_PAD_EN_O <= live;
            CARD_PAD_EN_O <= live;
            CARD_DETECT_N_PU_O <= 1'b1;
            LED_O <= live ? LED_I : RST_DRIVE_LOW;
            SPI_CS_N_O <= live ? SPI_CS_N_I : RST_SPI_CS_N;
            SPI_CLK_O <= live ? SPI_CLK_I : RST_DRIVE_LOW;
            SPI_DO_O <= live ? SPI_DO_I : RST_DRIVE_LOW;
            SPI_DO_OE_O <= live;
            FLASH_SPEED_STRAP_PD_O <= !live;
            DN_DATA_IE_O <= 1'b1;
            DN_DATA_PD_O <= !live;
            SPI_DI_PD_O <= !live;
            TEST_PD_O <= 1'b1;
        end
    end

    // Helper: cycles the pull-up has stayed on without upstream power
    logic [31:0] drop_cnt_reg;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            drop_cnt_reg <= 32'h0;
        else if (UP_PULLUP_EN_O && !vbus_s)
            drop_cnt_reg <= drop_cnt_reg + 32'h1;
        else
            drop_cnt_reg <= 32'h0;
    end

    sequence released_s;
        CE_I && phase_reg == STRAP_SAMPLE_PHASE;
    endsequence

    sequence strap_taken_s;
        FLASH_SPEED_O == $past(strap_s);
    endsequence

    pullup_needs_vbus_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        (CE_I && !vbus_s) |=> !UP_PULLUP_EN_O)
        else $error("pull-up on without upstream power");

    pullup_drop_bound_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        drop_cnt_reg < DROP_CYCLES[31:0])
        else $error("pull-up held too long after power loss");

    attach_after_cfg_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        UP_PULLUP_EN_O |-> CFG_DONE_O && $past(cfg_state_reg == CFG_READY))
        else $error("attach before configuration done");

    default_fallback_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        (CE_I && cfg_state_reg == CFG_PROBE && CFG_PROBE_DONE_I
         && !CFG_FLASH_FOUND_I && !CFG_EEPROM_FOUND_I)
        |=> cfg_src_reg == SRC_DEFAULT && cfg_state_reg == CFG_READY)
        else $error("defaults not chosen without a device");

    flash_first_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        (CE_I && cfg_state_reg == CFG_PROBE && CFG_PROBE_DONE_I
         && CFG_FLASH_FOUND_I) |=> cfg_src_reg == SRC_FLASH)
        else $error("flash source not selected");

    strap_capture_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        released_s |=> strap_taken_s ##1 !FLASH_SPEED_STRAP_PD_O)
        else $error("strap not latched at release");

    port_off_low_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        (CE_I && live && !PORT_POWER_REQ_I[0]) |=>
        PORT_POWER_CTL_OE_O[0] && !PORT_POWER_CTL_PU_O[0]
        && !PORT_POWER_CTL_O[0])
        else $error("unpowered port not driven low");

    port_on_high_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        (CE_I && live && PORT_POWER_REQ_I[0]) |=>
        !PORT_POWER_CTL_OE_O[0] && PORT_POWER_CTL_PU_O[0])
        else $error("powered port not released high");

    reset_pads_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        (phase_reg != RELEASE_PHASE) |->
        !CARD_PAD_EN_O && !UP_PAIR_PAD_EN_O && SPI_CS_N_O && !LED_O)
        else $error("pads left reset state early");

    tt_shape_a: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        TT_COUNT_O == 2'h1 && TT_NP_BUFFERS_O == 3'h4)
        else $error("translator shape wrong");
endmodule

// ### hub_reset_attach_pkg.sv
// Constants shared by the hub reset, strap and attach control logic.
// Assumes one 200 MHz reference clock and an active-low async reset.
package hub_reset_attach_pkg;

    // Transaction translator shape
    localparam logic [1:0] TT_COUNT = 2'h1;
    localparam logic [2:0] TT_NP_BUFFERS = 3'h4;

    // Serial EEPROM size in bytes
    localparam int unsigned CFG_EEPROM_BYTES = 512;

    // Timing
    localparam longint unsigned REF_CLK_HZ = 200_000_000;
    localparam longint unsigned PULLUP_DROP_S = 10;
    localparam longint unsigned PULLUP_DROP_CYCLES =
        PULLUP_DROP_S * REF_CLK_HZ;

    // Release sequence phases, counted in enabled clocks after reset
    localparam logic [1:0] STRAP_SAMPLE_PHASE = 2'h2;
    localparam logic [1:0] RELEASE_PHASE = 2'h3;

    // Configuration source codes
    typedef enum logic [1:0]
    {
        SRC_NONE = 2'b00,
        SRC_DEFAULT = 2'b01,
        SRC_EEPROM = 2'b10,
        SRC_FLASH = 2'b11
    } cfg_src_t;

    typedef enum logic [1:0]
    {
        CFG_HOLD = 2'b00,
        CFG_PROBE = 2'b01,
        CFG_LOAD = 2'b10,
        CFG_READY = 2'b11
    } cfg_state_t;

    // Pad values held in reset
    localparam logic RST_SPI_CS_N = 1'b1;
    localparam logic RST_DRIVE_LOW = 1'b0;

endpackage

// ### hub_pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the levels change slowly compared with the clock.
`timescale 1ns/1ps
module hub_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_reg <= '0;
            q_o <= '0;
        end
        else if (ce_i)
        begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// ### hub_cfg_loader_model.sv
// Behavioural configuration loader that answers the attach controller.
// Assumes it shares the reference clock and the active-low reset.
`timescale 1ns/1ps
module hub_cfg_loader_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Scenario control: bit 0 EEPROM present, bit 1 flash present
    input wire logic [1:0] mode_i,
    input wire logic [7:0] load_wait_i,
    // Loader handshake
    output logic probe_done_o,
    output logic flash_found_o,
    output logic eeprom_found_o,
    output logic load_done_o
);
    logic [7:0] cnt_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_reg <= 8'h00;
            probe_done_o <= 1'b0;
            flash_found_o <= 1'b0;
            eeprom_found_o <= 1'b0;
            load_done_o <= 1'b0;
        end
        else
        begin
            if (cnt_reg != 8'hff)
                cnt_reg <= cnt_reg + 8'h01;
            probe_done_o <= (cnt_reg == 8'h07);
            // Flags are only meaningful with probe done, so they churn
            if (cnt_reg == 8'h07)
            begin
                flash_found_o <= mode_i[1];
                eeprom_found_o <= mode_i[0];
            end
            else
            begin
                flash_found_o <= ~flash_found_o;
                eeprom_found_o <= ~eeprom_found_o;
            end
            // No device present means no load ever finishes
            load_done_o <= (mode_i != 2'h0) &&
                (cnt_reg == 8'h08 + load_wait_i);
        end
    end
endmodule

// ### hub_reset_attach_control_bench.sv
// Self-checking bench for the reset, strap and attach controller.
// Assumes the loader model stands in for the configuration devices.
`timescale 1ns/1ps
module hub_reset_attach_control_bench;
    import hub_reset_attach_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sense = 1'b1;
    logic strap = 1'b0;
    logic [1:0] req = 2'h3;
    logic [1:0] mode = 2'h0;
    logic [7:0] lwait = 8'h04;
    logic ce = 1'b1;
    logic sdo_in = 1'b0;
    logic probe, ffound, efound, ldone;
    logic pull, pair, card, cdpu, led, cs_n, sclk, sdo, sdo_oe;
    logic strap_pd, dn_ie, dn_pd, di_pd, test_pd, speed, done;
    logic [1:0] ctl, oe, pu, src, tt;
    logic [2:0] npb;
    int checks = 0;
    int miscompares = 0;
    int cyc = 0;

    hub_cfg_loader_model part_u (.clk_i(clk), .nrst_i(rst_n),
        .mode_i(mode), .load_wait_i(lwait), .probe_done_o(probe),
        .flash_found_o(ffound), .eeprom_found_o(efound),
        .load_done_o(ldone));

    hub_reset_attach_control #(.DROP_CYCLES(1000), .PORTS(2)) dut_u (
        .REF_CLK_I(clk), .NRST_I(rst_n), .CE_I(ce),
        .UPSTREAM_POWER_SENSE_I(sense), .FLASH_SPEED_STRAP_I(strap),
        .CFG_PROBE_DONE_I(probe), .CFG_FLASH_FOUND_I(ffound),
        .CFG_EEPROM_FOUND_I(efound), .CFG_LOAD_DONE_I(ldone),
        .PORT_POWER_REQ_I(req), .LED_I(1'b1), .SPI_CS_N_I(1'b0),
        .SPI_CLK_I(1'b1), .SPI_DO_I(sdo_in), .UP_PULLUP_EN_O(pull),
        .UP_PAIR_PAD_EN_O(pair), .CARD_PAD_EN_O(card),
        .CARD_DETECT_N_PU_O(cdpu), .PORT_POWER_CTL_O(ctl),
        .PORT_POWER_CTL_OE_O(oe), .PORT_POWER_CTL_PU_O(pu),
        .LED_O(led), .SPI_CS_N_O(cs_n), .SPI_CLK_O(sclk), .SPI_DO_O(sdo),
        .SPI_DO_OE_O(sdo_oe), .FLASH_SPEED_STRAP_PD_O(strap_pd),
        .DN_DATA_IE_O(dn_ie), .DN_DATA_PD_O(dn_pd), .SPI_DI_PD_O(di_pd),
        .TEST_PD_O(test_pd), .FLASH_SPEED_O(speed), .CFG_SRC_O(src),
        .CFG_DONE_O(done), .TT_COUNT_O(tt), .TT_NP_BUFFERS_O(npb));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task results;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Port requests are held high through reset to prove they are ignored
    task boot(input logic [1:0] m, input logic s, input logic st);
        @(negedge clk);
        rst_n = 1'b0;
        mode = m;
        sense = s;
        strap = st;
        req = 2'h3;
        repeat (8) @(negedge clk);
        check({pull, pair, card, cdpu, led, cs_n, sclk, sdo}, 8'h14);
        check({1'b0, sdo_oe, strap_pd, dn_ie, dn_pd, di_pd, test_pd, done},
            8'h3e);
        check({2'h0, ctl, oe, pu}, 8'h0c);
        check({6'h00, src}, 8'h00);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check({2'h0, ctl, oe, pu}, 8'h0c);
    endtask

    task wait_done;
        for (int i = 0; i < 300 && done !== 1'b1; i++)
        begin
            check({7'h00, pull}, 8'h00);
            @(negedge clk);
        end
        check({7'h00, done}, 8'h01);
    endtask

    task t_config(input logic [1:0] m, input logic s, input logic st,
        input logic [1:0] exp_src);
        boot(m, s, st);
        wait_done();
        check({6'h00, src}, {6'h00, exp_src});
        check({7'h00, speed}, {7'h00, st});
        check({pull, pair, card, cdpu, led, cs_n, sclk, sdo},
            {s, 7'h7a});
        check({1'b0, sdo_oe, strap_pd, dn_ie, dn_pd, di_pd, test_pd, done},
            8'h53);
        // The strap pin is now data out; its level must not reach speed
        strap = ~st;
        repeat (6) @(negedge clk);
        check({7'h00, speed}, {7'h00, st});
        check({7'h00, pull}, {7'h00, s});
        $display("test config mode %0d sense %0d done", m, s);
    endtask

    task t_ports;
        check({2'h0, ctl, oe, pu}, 8'h03);
        req = 2'h1;
        repeat (2) @(negedge clk);
        check({2'h0, ctl, oe, pu}, 8'h09);
        req = 2'h0;
        repeat (2) @(negedge clk);
        check({2'h0, ctl, oe, pu}, 8'h0c);
        $display("test port power done");
    endtask

    // Removal is far faster than the allowed bound, so a few cycles suffice
    task t_sense;
        sense = 1'b0;
        repeat (4) @(negedge clk);
        check({7'h00, pull}, 8'h00);
        sense = 1'b1;
        repeat (4) @(negedge clk);
        check({7'h00, pull}, 8'h01);
        $display("test upstream sense done");
    endtask

    // Enable low must freeze the synchroniser as well as the pads
    task t_enable;
        sdo_in = 1'b1;
        repeat (2) @(negedge clk);
        check({7'h00, sdo}, 8'h01);
        ce = 1'b0;
        req = 2'h3;
        sense = 1'b0;
        sdo_in = 1'b0;
        repeat (6) @(negedge clk);
        check({2'h0, ctl, oe, pu}, 8'h0c);
        check({6'h00, pull, sdo}, 8'h03);
        ce = 1'b1;
        repeat (5) @(negedge clk);
        check({2'h0, ctl, oe, pu}, 8'h03);
        check({6'h00, pull, sdo}, 8'h00);
        $display("test clock enable done");
    endtask

    task t_tt;
        check({3'h0, tt, npb}, 8'h0c);
        $display("test translator shape done");
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
    end

    initial
    begin
        t_config(2'h0, 1'b1, 1'b0, 2'h1);
        t_ports();
        t_sense();
        t_enable();
        t_tt();
        t_config(2'h0, 1'b0, 1'b1, 2'h1);
        t_config(2'h1, 1'b1, 1'b1, 2'h2);
        t_config(2'h2, 1'b1, 1'b0, 2'h3);
        t_config(2'h3, 1'b1, 1'b1, 2'h3);
        lwait = 8'h3c;
        t_config(2'h1, 1'b1, 1'b0, 2'h2);
        results();
    end
endmodule
